// ### rtl/fdc_ctrl_regs.svh
// Purpose: register map, command and status codes, reset values and timing constants of the control command unit
// Assumes: 32-bit AHB-Lite data, 100 MHz hclk
// Notes: every register takes one aligned word
`ifndef FDC_CTRL_REGS_SVH
`define FDC_CTRL_REGS_SVH

`define OFS_CMD 8'h00
`define OFS_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_RESULT 8'h0C
`define OFS_IDFIELD 8'h10
`define OFS_TIMING 8'h14

`define OP_READ_ID 4'h1
`define OP_RECAL 4'h2
`define OP_SEEK 4'h3
`define OP_REL_SEEK 4'h4
`define OP_SENSE_INT 4'h5
`define OP_SENSE_DRIVE 4'h6
`define OP_SPECIFY 4'h7

`define IC_NORMAL 2'h0
`define IC_ABNORMAL 2'h1
`define IC_INVALID 2'h2
`define IC_POLL 2'h3

`define RATE_500K 3'h0
`define RATE_300K 3'h1
`define RATE_250K 3'h2
`define RATE_1M 3'h3
`define RATE_2M 3'h4
`define MULT_2M 4'h1
`define MULT_1M 4'h2
`define MULT_500K 4'h4
`define MULT_300K 4'h7
`define MULT_250K 4'h8

`define RECAL_MAX_STEPS 7'h4F
`define SRT_SPAN 5'h10
`define HUT_SCALE 9'h010
`define HLT_SCALE 9'h002
`define TIMER_ZERO_UNITS 9'h100
`define DRIVES 4

`define CLK_PERIOD_NS 10
`define UNIT_TIME_NS 250000
`define STEP_PULSE_NS 1000
`define STEP_PULSE_CYC 7'(`STEP_PULSE_NS / `CLK_PERIOD_NS)

`define CTRL_RESET 32'h0000_0000
`define SPEC_RESET 16'h0000

`endif

// ### rtl/fdc_ctrl_pkg.sv
// Purpose: types shared by the control command unit
// Assumes: constants come from fdc_ctrl_regs.svh
// Notes: state codes are one-hot
`include "fdc_ctrl_regs.svh"

package fdc_ctrl_pkg;

  typedef enum logic [3:0] {
    DRV_IDLE = 4'b0001,
    DRV_SEEK = 4'b0010,
    DRV_RECAL = 4'b0100,
    DRV_REL = 4'b1000
  } drv_state_e;

  typedef enum logic [2:0] {
    RID_IDLE = 3'b001,
    RID_LOAD = 3'b010,
    RID_SEARCH = 3'b100
  } rid_state_e;

  function automatic logic [7:0] mk_st0(input logic [1:0] ic, input logic se, input logic ec,
                                         input logic head, input logic [1:0] drv);
    mk_st0 = {ic, se, ec, 1'b0, head, drv};
  endfunction : mk_st0

endpackage : fdc_ctrl_pkg

// ### rtl/floppy_control_command_unit.sv
// Purpose: control commands of a floppy controller (read id, recalibrate, seek, sense, specify) behind AHB-Lite
// Assumes: one hclk domain; drive pins pass a three-flop filter; id channel is on hclk
// Notes: four drives, each with its own stepping engine so seeks overlap
`include "fdc_ctrl_regs.svh"

module floppy_control_command_unit
  import fdc_ctrl_pkg::*;
#(
  parameter int UNIT_CYCLES = `UNIT_TIME_NS / `CLK_PERIOD_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] track_zero_n,
  input wire logic [3:0] write_protect_n,
  input wire logic index_pulse_n,
  input wire logic id_valid,
  input wire logic [7:0] id_cyl,
  input wire logic [7:0] id_head,
  input wire logic [7:0] id_sec,
  input wire logic [7:0] id_size,
  input wire logic xfer_req,
  output logic [3:0] step,
  output logic [3:0] dir,
  output logic [1:0] drive_sel,
  output logic head_sel,
  output logic head_load,
  output logic dma_req,
  output logic irq
);

  // ---------------- pin filter ----------------
  logic [8:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 9'h1FF;
      pin_s2_r <= 9'h1FF;
      pin_s3_r <= 9'h1FF;
      pin_f_r <= 9'h1FF;
    end else begin
      pin_s1_r <= {index_pulse_n, write_protect_n, track_zero_n};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      // a change counts only once two stages agree, filtering glitches off the cable
      for (int i = 0; i < 9; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) pin_f_r[i] <= pin_s3_r[i];
      end
    end
  end
  logic [3:0] tz_high;
  logic [3:0] wp_low;
  logic idx_n, idx_prev_r, idx_fall;
  assign tz_high = pin_f_r[3:0];
  assign wp_low = ~pin_f_r[7:4];
  assign idx_n = pin_f_r[8];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) idx_prev_r <= 1'b1;
    else idx_prev_r <= idx_n;
  end
  assign idx_fall = idx_prev_r & ~idx_n;

  // ---------------- AHB-Lite slave ----------------
  logic ap_wr_r, ap_rd_r;
  logic [7:0] ap_ofs_r;
  logic [31:0] ctrl_r, cmd_r, rd_mux;
  logic data_wr, cmd_wr;
  assign data_wr = ap_wr_r;
  assign cmd_wr = data_wr && ap_ofs_r == `OFS_CMD;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_ofs_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // zero wait states: read data is sampled at the address phase so it stands in the data phase
      ap_wr_r <= hsel && hready && htrans[1] && hwrite;
      ap_rd_r <= hsel && hready && htrans[1] && !hwrite;
      ap_ofs_r <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CTRL_RESET;
      cmd_r <= 32'h0000_0000;
    end else begin
      if (data_wr && ap_ofs_r == `OFS_CTRL) ctrl_r <= {27'h000_0000, hwdata[4:0]};
      if (cmd_wr) cmd_r <= hwdata;
    end
  end
  logic [2:0] rate;
  logic poll_dis, pd, pd_prev_r, pd_exit;
  assign rate = ctrl_r[2:0];
  assign poll_dis = ctrl_r[3];
  assign pd = ctrl_r[4];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pd_prev_r <= 1'b0;
    else pd_prev_r <= pd;
  end
  assign pd_exit = pd_prev_r & ~pd;

  // ---------------- command decode ----------------
  logic [3:0] op;
  logic [1:0] cdrv;
  logic chead, cdir;
  logic [7:0] ccyl;
  drv_state_e eng_r [`DRIVES];
  logic [3:0] dbusy_r;
  logic rid_active, any_rel, op_ok, cmd_go, refused_r;
  rid_state_e rid_r;
  assign op = hwdata[3:0];
  assign cdrv = hwdata[5:4];
  assign chead = hwdata[6];
  assign cdir = hwdata[7];
  assign ccyl = hwdata[15:8];
  assign rid_active = rid_r != RID_IDLE;
  always_comb begin
    any_rel = 1'b0;
    for (int d = 0; d < `DRIVES; d++) any_rel = any_rel | (eng_r[d] == DRV_REL);
  end
  always_comb begin
    unique case (op)
      `OP_READ_ID, `OP_SENSE_INT, `OP_SENSE_DRIVE, `OP_SPECIFY: op_ok = 1'b1;
      `OP_RECAL, `OP_SEEK: op_ok = eng_r[cdrv] == DRV_IDLE;
      `OP_REL_SEEK: op_ok = eng_r[cdrv] == DRV_IDLE && !any_rel;
      default: op_ok = 1'b0;
    endcase
  end
  assign cmd_go = cmd_wr && op_ok && !rid_active && !pd;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) refused_r <= 1'b0;
    else if (cmd_wr) refused_r <= !cmd_go;
  end

  // specify: step, unload and load times plus transfer mode
  logic [3:0] step_rate_time, head_unload_time;
  logic [6:0] head_load_time;
  logic nd;
  logic [15:0] spec_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) spec_r <= `SPEC_RESET;
    else if (pd_exit) spec_r <= `SPEC_RESET;
    else if (cmd_go && op == `OP_SPECIFY) spec_r <= hwdata[31:16];
  end
  assign step_rate_time = spec_r[3:0];
  assign head_unload_time = spec_r[7:4];
  assign head_load_time = spec_r[14:8];
  assign nd = spec_r[15];

  // ---------------- time base ----------------
  // 300K uses 7 units in place of 6.67: spacing there runs about 5 percent long
  logic [3:0] mult;
  logic [23:0] tick_lim, tick_cnt_r;
  logic tick;
  always_comb begin
    unique case (rate)
      `RATE_2M: mult = `MULT_2M;
      `RATE_1M: mult = `MULT_1M;
      `RATE_300K: mult = `MULT_300K;
      `RATE_250K: mult = `MULT_250K;
      default: mult = `MULT_500K;
    endcase
  end
  assign tick_lim = 24'(24'(UNIT_CYCLES) * 24'(mult) - 24'd1);
  assign tick = tick_cnt_r >= tick_lim;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_r <= 24'h00_0000;
    else if (tick) tick_cnt_r <= 24'h00_0000;
    else tick_cnt_r <= tick_cnt_r + 24'd1;
  end

  // ---------------- sense interrupt selection ----------------
  logic [3:0] pend_v_r;
  logic [7:0] pend_st0_r [`DRIVES];
  logic [7:0] pcn_r [`DRIVES];
  logic poll_pend_r, poll_live, sense_go, any_pend;
  logic [1:0] pick;
  logic [3:0] sense_clr;
  assign sense_go = cmd_go && op == `OP_SENSE_INT;
  assign poll_live = poll_pend_r && !poll_dis && !head_load;
  always_comb begin
    pick = 2'h0;
    any_pend = 1'b0;
    for (int d = `DRIVES - 1; d >= 0; d--) begin
      if (pend_v_r[d]) begin
        pick = 2'(d);
        any_pend = 1'b1;
      end
    end
    sense_clr = 4'h0;
    if (sense_go && !poll_live && any_pend) sense_clr[pick] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) poll_pend_r <= 1'b1;
    else if (sense_go && poll_live) poll_pend_r <= 1'b0;
    else if (poll_dis || pd_exit) poll_pend_r <= 1'b0;
  end

  // ---------------- per-drive stepping engines ----------------
  logic [7:0] tgt_r [`DRIVES];
  logic [6:0] nsteps_r [`DRIVES];
  logic [4:0] ival_r [`DRIVES];
  logic [6:0] pw_r [`DRIVES];
  logic [4:0] srt_units;
  assign srt_units = `SRT_SPAN - {1'b0, step_rate_time};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int d = 0; d < `DRIVES; d++) begin
        eng_r[d] <= DRV_IDLE;
        pcn_r[d] <= 8'h00;
        tgt_r[d] <= 8'h00;
        nsteps_r[d] <= 7'h00;
        ival_r[d] <= 5'h00;
        pw_r[d] <= 7'h00;
        pend_st0_r[d] <= 8'h00;
      end
      pend_v_r <= 4'h0;
      dbusy_r <= 4'h0;
      step <= 4'h0;
      dir <= 4'h0;
    end else begin
      for (int d = 0; d < `DRIVES; d++) begin
        if (pw_r[d] != 7'h00) pw_r[d] <= pw_r[d] - 7'd1;
        // pulse drops on the edge the count empties, so the line is low a cycle before any next step
        if (pw_r[d] <= 7'h01) step[d] <= 1'b0;
        // ticks are not aligned to the first step, so the first spacing can come short
        if (tick && ival_r[d] != 5'h00) ival_r[d] <= ival_r[d] - 5'd1;
        if (sense_clr[d]) begin
          pend_v_r[d] <= 1'b0;
          dbusy_r[d] <= 1'b0;
        end
        if (pd_exit) begin
          eng_r[d] <= DRV_IDLE;
          pcn_r[d] <= 8'h00;
          pend_v_r[d] <= 1'b0;
          pend_st0_r[d] <= 8'h00;
          dbusy_r[d] <= 1'b0;
        end else if (cmd_go && cdrv == 2'(d) && (op == `OP_RECAL || op == `OP_SEEK || op == `OP_REL_SEEK)) begin
          dbusy_r[d] <= 1'b1;
          ival_r[d] <= 5'h00;
          tgt_r[d] <= ccyl;
          nsteps_r[d] <= 7'h00;
          if (op == `OP_RECAL) begin
            eng_r[d] <= DRV_RECAL;
            pcn_r[d] <= 8'h00;
            dir[d] <= 1'b0;
          end else if (op == `OP_SEEK) begin
            eng_r[d] <= DRV_SEEK;
          end else begin
            eng_r[d] <= DRV_REL;
            dir[d] <= cdir;
          end
        end else if (eng_r[d] != DRV_IDLE && ival_r[d] == 5'h00 && pw_r[d] == 7'h00) begin
          unique case (eng_r[d])
            DRV_SEEK: begin
              if (pcn_r[d] == tgt_r[d]) begin
                eng_r[d] <= DRV_IDLE;
                pend_v_r[d] <= 1'b1;
                pend_st0_r[d] <= mk_st0(`IC_NORMAL, 1'b1, 1'b0, 1'b0, 2'(d));
              end else begin
                dir[d] <= pcn_r[d] < tgt_r[d];
                pcn_r[d] <= (pcn_r[d] < tgt_r[d]) ? pcn_r[d] + 8'd1 : pcn_r[d] - 8'd1;
                step[d] <= 1'b1;
                pw_r[d] <= `STEP_PULSE_CYC;
                ival_r[d] <= srt_units;
              end
            end
            DRV_RECAL: begin
              if (tz_high[d]) begin
                eng_r[d] <= DRV_IDLE;
                pend_v_r[d] <= 1'b1;
                pend_st0_r[d] <= mk_st0(`IC_NORMAL, 1'b1, 1'b0, 1'b0, 2'(d));
              end else if (nsteps_r[d] == `RECAL_MAX_STEPS) begin
                eng_r[d] <= DRV_IDLE;
                pend_v_r[d] <= 1'b1;
                pend_st0_r[d] <= mk_st0(`IC_ABNORMAL, 1'b1, 1'b1, 1'b0, 2'(d));
              end else begin
                nsteps_r[d] <= nsteps_r[d] + 7'd1;
                step[d] <= 1'b1;
                pw_r[d] <= `STEP_PULSE_CYC;
                ival_r[d] <= srt_units;
              end
            end
            DRV_REL: begin
              if (tgt_r[d] == 8'h00) begin
                eng_r[d] <= DRV_IDLE;
                pend_v_r[d] <= 1'b1;
                pend_st0_r[d] <= mk_st0(`IC_NORMAL, 1'b1, 1'b0, 1'b0, 2'(d));
              end else if (!dir[d] && tz_high[d]) begin
                eng_r[d] <= DRV_IDLE;
                pend_v_r[d] <= 1'b1;
                pend_st0_r[d] <= mk_st0(`IC_ABNORMAL, 1'b1, 1'b1, 1'b0, 2'(d));
              end else begin
                tgt_r[d] <= tgt_r[d] - 8'd1;
                pcn_r[d] <= dir[d] ? pcn_r[d] + 8'd1 : pcn_r[d] - 8'd1;
                step[d] <= 1'b1;
                pw_r[d] <= `STEP_PULSE_CYC;
                ival_r[d] <= srt_units;
              end
            end
            default: eng_r[d] <= DRV_IDLE;
          endcase
        end
      end
    end
  end

  // ---------------- read id, head timers and result registers ----------------
  logic [8:0] hd_cnt_r;
  logic [1:0] idx_seen_r;
  logic unload_run_r, result_int_r, result_valid_r;
  logic [7:0] res_st0_r, res_st1_r, res_st3_r, res_pcn_r;
  logic [31:0] idf_r;
  logic [8:0] hlt_units, hut_units;
  assign hlt_units = (head_load_time == 7'h00) ? `TIMER_ZERO_UNITS : 9'({2'h0, head_load_time} * `HLT_SCALE);
  assign hut_units = (head_unload_time == 4'h0) ? `TIMER_ZERO_UNITS : 9'({5'h00, head_unload_time} * `HUT_SCALE);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rid_r <= RID_IDLE;
      hd_cnt_r <= 9'h000;
      idx_seen_r <= 2'h0;
      unload_run_r <= 1'b0;
      head_load <= 1'b0;
      drive_sel <= 2'h0;
      head_sel <= 1'b0;
      result_int_r <= 1'b0;
      result_valid_r <= 1'b0;
      res_st0_r <= 8'h00;
      res_st1_r <= 8'h00;
      res_st3_r <= 8'h00;
      res_pcn_r <= 8'h00;
      idf_r <= 32'h0000_0000;
    end else if (pd_exit) begin
      rid_r <= RID_IDLE;
      result_int_r <= 1'b0;
      result_valid_r <= 1'b0;
      res_st0_r <= 8'h00;
      res_st1_r <= 8'h00;
      res_st3_r <= 8'h00;
      res_pcn_r <= 8'h00;
      idf_r <= 32'h0000_0000;
    end else begin
      if (tick && hd_cnt_r != 9'h000) hd_cnt_r <= hd_cnt_r - 9'd1;
      if (unload_run_r && hd_cnt_r == 9'h000) begin
        unload_run_r <= 1'b0;
        head_load <= 1'b0;
      end
      if (cmd_go) begin
        result_int_r <= 1'b0;
        result_valid_r <= 1'b0;
      end
      if (cmd_go && op == `OP_READ_ID) begin
        drive_sel <= cdrv;
        head_sel <= chead;
        idx_seen_r <= 2'h0;
        unload_run_r <= 1'b0;
        head_load <= 1'b1;
        // a head still loaded needs no new settle time
        if (head_load) rid_r <= RID_SEARCH;
        else begin
          rid_r <= RID_LOAD;
          hd_cnt_r <= hlt_units;
        end
      end else if (sense_go) begin
        result_valid_r <= 1'b1;
        if (poll_live) begin
          res_st0_r <= mk_st0(`IC_POLL, 1'b0, 1'b0, 1'b0, 2'h0);
          res_pcn_r <= pcn_r[0];
        end else if (any_pend) begin
          res_st0_r <= pend_st0_r[pick];
          res_pcn_r <= pcn_r[pick];
        end else begin
          res_st0_r <= mk_st0(`IC_INVALID, 1'b0, 1'b0, 1'b0, 2'h0);
          res_pcn_r <= 8'h00;
        end
      end else if (cmd_go && op == `OP_SENSE_DRIVE) begin
        result_valid_r <= 1'b1;
        res_st3_r <= {1'b0, wp_low[cdrv], 1'b1, tz_high[cdrv], 1'b1, chead, cdrv};
      end
      unique case (rid_r)
        RID_IDLE: ;
        RID_LOAD: if (hd_cnt_r == 9'h000) rid_r <= RID_SEARCH;
        RID_SEARCH: begin
          if (id_valid) begin
            idf_r <= {id_cyl, id_head, id_sec, id_size};
            res_st0_r <= mk_st0(`IC_NORMAL, 1'b0, 1'b0, head_sel, drive_sel);
            res_st1_r <= 8'h00;
          end else if (idx_fall && idx_seen_r == 2'h1) begin
            res_st0_r <= mk_st0(`IC_ABNORMAL, 1'b0, 1'b0, head_sel, drive_sel);
            res_st1_r <= 8'h01;
          end else if (idx_fall) idx_seen_r <= idx_seen_r + 2'd1;
          if (id_valid || (idx_fall && idx_seen_r == 2'h1)) begin
            rid_r <= RID_IDLE;
            result_int_r <= 1'b1;
            result_valid_r <= 1'b1;
            unload_run_r <= 1'b1;
            hd_cnt_r <= hut_units;
          end
        end
        default: rid_r <= RID_IDLE;
      endcase
    end
  end

  // ---------------- busy, transfer request, interrupt ----------------
  logic busy_r, xfer_np;
  assign xfer_np = nd && xfer_req;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      dma_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      // seeks show busy only for the cycle that takes the command
      busy_r <= cmd_go || (rid_active && !(rid_r == RID_SEARCH && id_valid));
      dma_req <= !nd && xfer_req;
      irq <= (|(pend_v_r & ~sense_clr)) | (poll_live && !sense_go) | result_int_r | xfer_np;
    end
  end

  always_comb begin
    unique case (haddr[7:0])
      `OFS_CMD: rd_mux = cmd_r;
      `OFS_CTRL: rd_mux = ctrl_r;
      `OFS_STATUS: rd_mux = {16'h0000, 4'h0, dbusy_r, 1'b0, head_load, nd, refused_r, result_valid_r, irq,
                             !busy_r || xfer_np, busy_r};
      `OFS_RESULT: rd_mux = {res_pcn_r, res_st3_r, res_st1_r, res_st0_r};
      `OFS_IDFIELD: rd_mux = idf_r;
      `OFS_TIMING: rd_mux = {16'h0000, spec_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

endmodule : floppy_control_command_unit

// ### tb/fcu_drive_model.sv
// Purpose: behavioural drives on the far side of the control command unit
// Assumes: the disk spins freely, so index pulses never stop
// Notes: track_zero_n reads high at track 0, the reading this design takes
module fcu_drive_model (
  input wire logic hclk,
  input wire logic [3:0] step,
  input wire logic [3:0] dir,
  input wire logic id_on,
  output logic [3:0] track_zero_n,
  output logic index_pulse_n,
  output logic id_valid,
  output logic [7:0] id_cyl,
  output logic [7:0] id_head,
  output logic [7:0] id_sec,
  output logic [7:0] id_size
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos [4] = '{3, 90, 0, 0};
  logic [3:0] step_q = 4'h0;
  int spin = 0;
  always @(posedge hclk) begin
    step_q <= step;
    spin <= (spin + 1) % 300;
    for (int d = 0; d < 4; d++)
      if (step[d] && !step_q[d]) pos[d] <= dir[d] ? pos[d] + 1 : (pos[d] > 0 ? pos[d] - 1 : 0);
  end
  always_comb begin
    for (int d = 0; d < 4; d++) track_zero_n[d] = (pos[d] == 0);
  end
  assign index_pulse_n = !(spin < 10);
  assign id_valid = id_on && spin == 150;
  // outside the id pulse the field bytes churn, so a stale capture shows
  assign id_cyl = id_valid ? 8'(pos[0]) : 8'(spin);
  assign id_head = id_valid ? 8'h00 : 8'(spin);
  assign id_sec = id_valid ? 8'h07 : 8'(spin);
  assign id_size = id_valid ? 8'h02 : 8'(spin);
endmodule : fcu_drive_model

// ### tb/floppy_control_command_unit_properties.sv
// Purpose: port-level assertions for the control command unit
// Assumes: one hclk domain; drive 0 carries the stepping checks
// Notes: bound to the design top below
`include "fdc_ctrl_regs.svh"
module floppy_control_command_unit_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic xfer_req,
  input wire logic [3:0] step,
  input wire logic [3:0] dir,
  input wire logic dma_req,
  input wire logic irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic take_r, cmd_r, recal_r;
  logic [7:0] hi_r;
  wire take = hsel && hreadyout && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      take_r <= 1'b0;
      cmd_r <= 1'b0;
    end else begin
      take_r <= take && !hwrite;
      cmd_r <= take && hwrite && haddr[7:0] == `OFS_CMD;
    end
  end
  // a refused recalibrate would still set this; the bench never sends one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) recal_r <= 1'b0;
    else if (cmd_r && hwdata[5:4] == 2'h0 && hwdata[3:0] inside {`OP_RECAL, `OP_SEEK, `OP_REL_SEEK})
      recal_r <= hwdata[3:0] == `OP_RECAL;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hi_r <= 8'h00;
    else hi_r <= step[0] ? hi_r + 8'h01 : 8'h00;
  end
  a_ready_zero_wait: assert property (hreadyout)
    else $error("hreadyout dropped");
  a_resp_always_okay: assert property (!hresp)
    else $error("error response on the bus");
  a_rdata_holds: assert property (!take_r |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  a_poll_after_reset: assert property ($rose(hresetn) |-> ##[0:2] irq)
    else $error("no poll interrupt after reset");
  a_dma_has_cause: assert property (dma_req |-> $past(xfer_req))
    else $error("dma request without transfer need");
  a_step_pulse_width: assert property ($fell(step[0]) |-> hi_r == 8'h64)
    else $error("step pulse width wrong");
  a_dir_steady_step: assert property (step[0] && $past(step[0]) |-> $stable(dir[0]))
    else $error("direction changed within a step");
  a_recal_steps_out: assert property (recal_r && step[0] |-> !dir[0])
    else $error("recalibrate stepped inward");
  a_quiet_commands: assert property (cmd_r && hwdata[3:0] inside {`OP_SENSE_DRIVE, `OP_SPECIFY} && !irq |=> !irq [*3])
    else $error("interrupt after a quiet command");
endmodule : floppy_control_command_unit_properties

bind floppy_control_command_unit floppy_control_command_unit_properties floppy_control_command_unit_properties_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
  .hreadyout, .hresp, .xfer_req, .step, .dir, .dma_req, .irq);

// ### tb/floppy_control_command_unit_bench.sv
// Purpose: self-checking bench for the control command unit
// Assumes: UNIT_CYCLES of 4 shortens every unit-based timer; the step pulse stays 100 cycles
// Notes: every seek is closed by a sense so drive busy flags clear
`include "fdc_ctrl_regs.svh"
module floppy_control_command_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic xfer_req = 1'b0;
  logic id_on = 1'b0;
  logic [31:0] hrdata, r;
  logic hreadyout, irq, dma_req, id_valid, index_pulse_n;
  logic [3:0] step, dir, track_zero_n;
  logic [7:0] id_cyl, id_head, id_sec, id_size;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  always #5 hclk = ~hclk;
  floppy_control_command_unit #(.UNIT_CYCLES(4)) floppy_control_command_unit_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .track_zero_n(track_zero_n), .write_protect_n(4'hF), .index_pulse_n(index_pulse_n),
    .id_valid(id_valid), .id_cyl(id_cyl), .id_head(id_head), .id_sec(id_sec), .id_size(id_size),
    .xfer_req(xfer_req), .step(step), .dir(dir), .drive_sel(), .head_sel(), .head_load(),
    .dma_req(dma_req), .irq(irq));
  fcu_drive_model fcu_drive_model_i (.hclk(hclk), .step(step), .dir(dir), .id_on(id_on),
    .track_zero_n(track_zero_n), .index_pulse_n(index_pulse_n), .id_valid(id_valid),
    .id_cyl(id_cyl), .id_head(id_head), .id_sec(id_sec), .id_size(id_size));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic cmd(input logic [3:0] op, input logic [1:0] drv, input logic [7:0] new_cylinder);
    bus(1'b1, `OFS_CMD, {16'h000F, new_cylinder, 2'h0, drv, op});
  endtask : cmd
  // the first two edges let a clearing command drop a stale interrupt
  task automatic wait_irq();
    int n = 0;
    repeat (2) @(posedge hclk);
    while (irq !== 1'b1 && n < 40000) begin
      @(posedge hclk);
      n++;
    end
    chk(irq, 32'h1);
  endtask : wait_irq
  task automatic sense_end(input logic [7:0] st0);
    wait_irq();
    cmd(`OP_SENSE_INT, 2'h0, 8'h00);
    bus(1'b0, `OFS_RESULT, 32'h0);
    chk(r[7:0], st0);
    chk(irq, 32'h0);
  endtask : sense_end
  task automatic t_poll();
    sense_end(8'hC0);
    bus(1'b1, `OFS_CTRL, {29'h0, `RATE_2M});
    bus(1'b1, `OFS_CMD, 32'h000F_0007);
    bus(1'b0, `OFS_TIMING, 32'h0);
    chk(r, 32'h0000_000F);
    $display("test poll done");
  endtask : t_poll
  task automatic t_recal();
    cmd(`OP_RECAL, 2'h0, 8'h00);
    cmd(`OP_RECAL, 2'h1, 8'h00);
    repeat (2) @(posedge hclk);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(r[11:0], 12'h302);
    sense_end(8'h20);
    chk(r[31:24], 8'h00);
    sense_end(8'h71);
    chk(32'(fcu_drive_model_i.pos[1]), 32'hB);
    $display("test recal done");
  endtask : t_recal
  task automatic t_seek();
    cmd(`OP_SEEK, 2'h0, 8'h05);
    cmd(`OP_SEEK, 2'h1, 8'h09);
    sense_end(8'h20);
    chk(r[31:24], 8'h05);
    sense_end(8'h21);
    chk(r[31:24], 8'h09);
    cmd(`OP_SEEK, 2'h0, 8'h02);
    sense_end(8'h20);
    chk(32'(fcu_drive_model_i.pos[0]), 32'h2);
    chk(32'(fcu_drive_model_i.pos[1]), 32'h14);
    $display("test seek done");
  endtask : t_seek
  task automatic t_read_id();
    cmd(`OP_READ_ID, 2'h0, 8'h00);
    wait_irq();
    bus(1'b0, `OFS_RESULT, 32'h0);
    chk(r[15:0], 16'h0140);
    id_on <= 1'b1;
    cmd(`OP_READ_ID, 2'h0, 8'h00);
    wait_irq();
    bus(1'b0, `OFS_RESULT, 32'h0);
    chk(r[7:0], 8'h00);
    bus(1'b0, `OFS_IDFIELD, 32'h0);
    chk(r, 32'h0200_0702);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(r[6], 1'b1);
    $display("test read id done");
  endtask : t_read_id
  task automatic t_quiet();
    xfer_req <= 1'b1;
    bus(1'b1, `OFS_CMD, 32'h000F_0007);
    cmd(`OP_SENSE_DRIVE, 2'h0, 8'h00);
    repeat (3) @(posedge hclk);
    chk(irq, 32'h0);
    chk(dma_req, 32'h1);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(r[3], 1'b1);
    // byte requests raise the interrupt in non-dma mode, so keep them off while the mode changes
    xfer_req <= 1'b0;
    bus(1'b1, `OFS_CMD, 32'h800F_0007);
    repeat (3) @(posedge hclk);
    chk(irq, 32'h0);
    xfer_req <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(irq, 32'h1);
    chk(dma_req, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(r[5], 1'b1);
    chk(r[2:1], 2'h3);
    xfer_req <= 1'b0;
    repeat (3) @(posedge hclk);
    $display("test quiet done");
  endtask : t_quiet
  task automatic t_power();
    chk(irq, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h14);
    bus(1'b1, `OFS_CTRL, 32'h4);
    // the clear lands one edge after the control write
    @(posedge hclk);
    bus(1'b0, `OFS_RESULT, 32'h0);
    chk(r, 32'h0);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    $display("test power done");
  endtask : t_power
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // ceiling sits well above the long failing recalibrate
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_poll();
    t_recal();
    t_seek();
    t_read_id();
    t_quiet();
    t_power();
    tally_and_finish();
  end
endmodule : floppy_control_command_unit_bench
